// ---- hdl/pm_msg_pkg.sv ----
// Package: constants for the power-management message header builder.
// Assumes a 4DW message TLP header presented as four 32-bit words.
package pm_msg_pkg;

  // ****************************************
  // Message types, codes and routing
  // ****************************************
  typedef enum logic [1:0] {
    MSG_ASPM_REJECT,
    MSG_PME,
    MSG_TURN_OFF,
    MSG_TURN_OFF_ACK
  } pm_msg_t;

  localparam logic [7:0] CODE_ASPM_REJECT   = 8'h14;
  localparam logic [7:0] CODE_PME           = 8'h18;
  localparam logic [7:0] CODE_TURN_OFF      = 8'h19;
  localparam logic [7:0] CODE_TURN_OFF_ACK  = 8'h1B;

  localparam logic [2:0] ROUTE_LOCAL        = 3'h4;
  localparam logic [2:0] ROUTE_TO_ROOT      = 3'h0;
  localparam logic [2:0] ROUTE_BCAST_DOWN   = 3'h3;
  localparam logic [2:0] ROUTE_GATHER_UP    = 3'h5;

  // ****************************************
  // Header field values
  // ****************************************
  localparam logic [1:0] FMT_4DW_NODATA     = 2'h1;
  localparam logic [1:0] TYPE_MSG_HI        = 2'h2;
  localparam logic [2:0] TC_DEFAULT         = 3'h0;
  localparam logic [1:0] ATTR_DEFAULT       = 2'h0;
  localparam logic [9:0] LENGTH_RSVD        = 10'h000;
  localparam logic [31:0] ADDR_RSVD         = 32'h0000_0000;
  localparam logic [7:0] TAG_DEFAULT        = 8'h00;
  localparam logic [2:0] FUNC_ZERO          = 3'h0;
  localparam logic [7:0] BUS_RESET          = 8'h00;
  localparam logic [4:0] DEV_RESET          = 5'h00;

  // Header bit positions within dword 0, dword 1 and the requester ID
  localparam int FMT_POS    = 29;
  localparam int TYPE_POS   = 24;
  localparam int TC_POS     = 20;
  localparam int ATTR_POS   = 12;
  localparam int REQID_POS  = 16;
  localparam int BUS_POS    = 8;
  localparam int DEV_POS    = 3;

endpackage

// ---- hdl/pm_msg_builder.sv ----
// Power-management message header builder and classifier, one port.
// Assumes the caller holds a request until accepted and that config-write
// capture strobes come from the port's Type 0 configuration decoder.
`timescale 1ns/1ps
`default_nettype none

module pm_msg_builder
  import pm_msg_pkg::*;
#(
  parameter int  DS_PORTS    = 4,
  parameter bit  IS_ENDPOINT = 1'b1,
  parameter bit  IS_SWITCH   = 1'b0,
  parameter bit  LEGACY_ID   = 1'b0
) (
  input  wire logic                i_clk,
  input  wire logic                i_srst,
  // Type 0 configuration write completed by this function
  input  wire logic                i_cfg_wr,
  input  wire logic [7:0]          i_cfg_bus,
  input  wire logic [4:0]          i_cfg_dev,
  // Transmit request
  input  wire logic                i_tx_req,
  input  wire pm_msg_t             i_tx_type,
  input  wire logic [2:0]          i_tx_func,
  output logic                     o_tx_busy,
  output logic                     o_tx_valid,
  output logic [31:0]              o_tx_dw0,
  output logic [31:0]              o_tx_dw1,
  output logic [31:0]              o_tx_dw2,
  output logic [31:0]              o_tx_dw3,
  // Received message header words 0 and 1
  input  wire logic                i_rx_valid,
  input  wire logic [31:0]         i_rx_dw0,
  input  wire logic [31:0]         i_rx_dw1,
  input  wire logic [DS_PORTS-1:0] i_rx_port,
  output logic                     o_rx_valid,
  output logic                     o_rx_known,
  output pm_msg_t                  o_rx_type,
  output logic                     o_rx_fwd_up,
  output logic                     o_rx_terminate
);

  // ****************************************
  // Lookup by message type
  // ****************************************
  typedef struct packed {
    logic [7:0] code;
    logic [2:0] route;
    logic       func_in_id;
  } msg_desc_t;

  function automatic msg_desc_t lookup(input pm_msg_t t);
    msg_desc_t d;
    d = '{code: CODE_PME, route: ROUTE_TO_ROOT, func_in_id: 1'b1};
    unique case (t)
      MSG_ASPM_REJECT: begin
        d = '{CODE_ASPM_REJECT, ROUTE_LOCAL, !LEGACY_ID};
      end
      MSG_PME: begin
        d = '{CODE_PME, ROUTE_TO_ROOT, IS_ENDPOINT};
      end
      MSG_TURN_OFF: begin
        d = '{CODE_TURN_OFF, ROUTE_BCAST_DOWN, 1'b1};
      end
      MSG_TURN_OFF_ACK: begin
        d = '{CODE_TURN_OFF_ACK, ROUTE_GATHER_UP, LEGACY_ID};
      end
    endcase
    return d;
  endfunction

  // ****************************************
  // Bus and device capture
  // ****************************************
  logic [7:0] bus_r;
  logic [7:0] bus_nxt;
  logic [4:0] dev_r;
  logic [4:0] dev_nxt;

  always_comb begin
    bus_nxt = bus_r;
    dev_nxt = dev_r;
    // Re-captured on every write: numbers may change at run time
    if (i_cfg_wr) begin
      bus_nxt = i_cfg_bus;
      dev_nxt = i_cfg_dev;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bus_r <= BUS_RESET;
      dev_r <= DEV_RESET;
    end else begin
      bus_r <= bus_nxt;
      dev_r <= dev_nxt;
    end
  end

  // ****************************************
  // Header builder
  // ****************************************
  logic        tx_valid_r;
  logic        tx_valid_nxt;
  logic [31:0] dw0_r;
  logic [31:0] dw0_nxt;
  logic [31:0] dw1_r;
  logic [31:0] dw1_nxt;
  logic [31:0] dw2_r;
  logic [31:0] dw2_nxt;
  logic [31:0] dw3_r;
  logic [31:0] dw3_nxt;
  msg_desc_t   tx_desc;
  logic [2:0]  tx_fn;
  logic        sw_ack_send;

  always_comb begin
    tx_desc      = lookup(i_tx_type);
    tx_fn        = tx_desc.func_in_id ? i_tx_func : FUNC_ZERO;
    tx_valid_nxt = 1'b0;
    dw0_nxt      = dw0_r;
    dw1_nxt      = dw1_r;
    dw2_nxt      = dw2_r;
    dw3_nxt      = dw3_r;
    if ((i_tx_req && !tx_valid_r) || sw_ack_send) begin
      if (sw_ack_send) begin
        tx_desc = lookup(MSG_TURN_OFF_ACK);
        tx_fn   = tx_desc.func_in_id ? i_tx_func : FUNC_ZERO;
      end
      tx_valid_nxt = 1'b1;
      dw0_nxt = 32'h0000_0000;
      dw0_nxt[FMT_POS +: 2]  = FMT_4DW_NODATA;
      dw0_nxt[TYPE_POS +: 5] = {TYPE_MSG_HI, tx_desc.route};
      dw0_nxt[TC_POS +: 3]   = TC_DEFAULT;
      dw0_nxt[ATTR_POS +: 2] = ATTR_DEFAULT;
      dw0_nxt[9:0]           = LENGTH_RSVD;
      dw1_nxt = {bus_r, dev_r, tx_fn, TAG_DEFAULT, tx_desc.code};
      dw2_nxt = ADDR_RSVD;
      dw3_nxt = ADDR_RSVD;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_valid_r <= 1'b0;
      dw0_r      <= 32'h0000_0000;
      dw1_r      <= 32'h0000_0000;
      dw2_r      <= 32'h0000_0000;
      dw3_r      <= 32'h0000_0000;
    end else begin
      tx_valid_r <= tx_valid_nxt;
      dw0_r      <= dw0_nxt;
      dw1_r      <= dw1_nxt;
      dw2_r      <= dw2_nxt;
      dw3_r      <= dw3_nxt;
    end
  end

  // ****************************************
  // Receive classifier and ack merge
  // ****************************************
  logic                rx_valid_r;
  logic                rx_known_r;
  pm_msg_t             rx_type_r;
  logic                rx_fwd_r;
  logic                rx_term_r;
  logic [DS_PORTS-1:0] ack_seen_r;
  logic [DS_PORTS-1:0] ack_seen_nxt;
  logic                rx_known_nxt;
  pm_msg_t             rx_type_nxt;
  logic                rx_fwd_nxt;
  logic                rx_term_nxt;
  logic [7:0]          rx_code;
  logic                rx_is_ack;
  msg_desc_t           rx_desc;

  always_comb begin
    // Only code and routing are examined; Length and Address are ignored
    rx_code      = i_rx_dw1[7:0];
    rx_known_nxt = 1'b1;
    rx_type_nxt  = MSG_PME;
    rx_fwd_nxt   = 1'b0;
    rx_term_nxt  = 1'b0;
    unique case (rx_code)
      CODE_ASPM_REJECT:  begin
        rx_type_nxt = MSG_ASPM_REJECT;
        rx_term_nxt = 1'b1;
      end
      CODE_PME:          begin
        rx_type_nxt = MSG_PME;
        rx_fwd_nxt  = IS_SWITCH;
      end
      CODE_TURN_OFF:     begin
        rx_type_nxt = MSG_TURN_OFF;
      end
      CODE_TURN_OFF_ACK: begin
        rx_type_nxt = MSG_TURN_OFF_ACK;
      end
      default:           begin
        rx_known_nxt = 1'b0;
      end
    endcase
    rx_desc      = lookup(rx_type_nxt);
    if (i_rx_dw0[TYPE_POS +: 3] != rx_desc.route) begin
      rx_known_nxt = 1'b0;
    end
    rx_is_ack    = i_rx_valid && rx_known_nxt
                   && rx_type_nxt == MSG_TURN_OFF_ACK;
    ack_seen_nxt = ack_seen_r;
    sw_ack_send  = 1'b0;
    if (IS_SWITCH && rx_is_ack) begin
      ack_seen_nxt = ack_seen_r | i_rx_port;
      // Ack goes upstream once every downstream port has answered
      if (&ack_seen_nxt) begin
        sw_ack_send  = 1'b1;
        ack_seen_nxt = '0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rx_valid_r <= 1'b0;
      rx_known_r <= 1'b0;
      rx_type_r  <= MSG_PME;
      rx_fwd_r   <= 1'b0;
      rx_term_r  <= 1'b0;
      ack_seen_r <= '0;
    end else begin
      rx_valid_r <= i_rx_valid;
      rx_known_r <= rx_known_nxt;
      rx_type_r  <= rx_type_nxt;
      rx_fwd_r   <= rx_fwd_nxt;
      rx_term_r  <= rx_term_nxt;
      ack_seen_r <= ack_seen_nxt;
    end
  end

  // A switch-merged ack takes the slot; a held local request waits two cycles (ack cycle, then busy cycle)
  assign o_tx_busy      = tx_valid_r;
  assign o_tx_valid     = tx_valid_r;
  assign o_tx_dw0       = dw0_r;
  assign o_tx_dw1       = dw1_r;
  assign o_tx_dw2       = dw2_r;
  assign o_tx_dw3       = dw3_r;
  assign o_rx_valid     = rx_valid_r;
  assign o_rx_known     = rx_known_r;
  assign o_rx_type      = rx_type_r;
  assign o_rx_fwd_up    = rx_fwd_r;
  assign o_rx_terminate = rx_term_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_route_local;
    @(posedge i_clk) disable iff (i_srst)
      tx_valid_nxt && dw1_nxt[7:0] == CODE_ASPM_REJECT
        |=> o_tx_dw0[26:24] == ROUTE_LOCAL;
  endproperty
  a_route_local: assert property (p_route_local)
    else $error("rejection routing wrong");

  property p_pme_route;
    @(posedge i_clk) disable iff (i_srst)
      o_tx_valid && o_tx_dw1[7:0] == CODE_PME
        |-> o_tx_dw0[26:24] == ROUTE_TO_ROOT && o_tx_dw0[22:20] == TC_DEFAULT;
  endproperty
  a_pme_route: assert property (p_pme_route)
    else $error("pme routing or class wrong");

  property p_ack_route;
    @(posedge i_clk) disable iff (i_srst)
      o_tx_valid && o_tx_dw1[7:0] == CODE_TURN_OFF_ACK
        |-> o_tx_dw0[26:24] == ROUTE_GATHER_UP;
  endproperty
  a_ack_route: assert property (p_ack_route)
    else $error("ack routing wrong");

  property p_rsvd;
    @(posedge i_clk) disable iff (i_srst)
      o_tx_valid |-> o_tx_dw0[9:0] == LENGTH_RSVD && o_tx_dw2 == ADDR_RSVD
                     && o_tx_dw0[13:12] == ATTR_DEFAULT;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved or attribute field nonzero");

  property p_pme_func;
    @(posedge i_clk) disable iff (i_srst)
      o_tx_valid && o_tx_dw1[7:0] == CODE_PME && !IS_ENDPOINT
        |-> o_tx_dw1[18:16] == FUNC_ZERO;
  endproperty
  a_pme_func: assert property (p_pme_func)
    else $error("non-endpoint pme function nonzero");

  sequence s_cfg_then_req;
    i_cfg_wr ##1 (i_tx_req && !o_tx_valid && !i_cfg_wr);
  endsequence

  property p_capture;
    @(posedge i_clk) disable iff (i_srst)
      s_cfg_then_req |=> o_tx_dw1[31:24] == $past(i_cfg_bus, 2);
  endproperty
  a_capture: assert property (p_capture)
    else $error("captured bus not used");

  property p_reject_term;
    @(posedge i_clk) disable iff (i_srst)
      i_rx_valid && i_rx_dw1[7:0] == CODE_ASPM_REJECT
        |=> o_rx_terminate && !o_rx_fwd_up;
  endproperty
  a_reject_term: assert property (p_reject_term)
    else $error("rejection not terminated");

  property p_tx_one;
    @(posedge i_clk) disable iff (i_srst)
      i_tx_req && !o_tx_valid |=> o_tx_valid;
  endproperty
  a_tx_one: assert property (p_tx_one)
    else $error("request not built");

endmodule

`default_nettype wire

// ---- verif/pm_link_partner.sv ----
// Link partner model: hands power-management message headers to the port.
// Assumes the bench asks for one message at a time through i_send.
`timescale 1ns/1ps
`default_nettype none
module pm_link_partner
  import pm_msg_pkg::*;
(
  input  wire logic    i_clk,
  input  wire logic    i_send,
  input  wire logic [1:0] i_bad,
  input  wire pm_msg_t i_type,
  output logic         o_valid,
  output logic [31:0]  o_dw0,
  output logic [31:0]  o_dw1
);
  logic [10:0] rc;

  always_comb begin
    case (i_type)
      MSG_ASPM_REJECT: rc = {3'h4, 8'h14};
      MSG_PME:         rc = {3'h0, 8'h18};
      MSG_TURN_OFF:    rc = {3'h3, 8'h19};
      default:         rc = {3'h5, 8'h1B};
    endcase
    // Unknown code only when a scenario asks for it
    if (i_bad[0]) begin
      rc[7:0] = 8'h7F;
    end
    // Good code on a wrong route must not be taken as known
    if (i_bad[1]) begin
      rc[10:8] = ~rc[10:8];
    end
  end

  // Junk in Length proves the receiver ignores reserved fields
  always_ff @(posedge i_clk) begin
    o_valid <= i_send;
    if (i_send) begin
      o_dw0 <= {3'h1, 2'h2, rc[10:8], 14'h0000, 10'h2A5};
      o_dw1 <= {16'h0100, 8'h00, rc[7:0]};
    end else begin
      // Released lines flip instead of holding the old header
      o_dw0 <= ~o_dw0;
      o_dw1 <= ~o_dw1;
    end
  end
endmodule
`default_nettype wire

// ---- verif/power_mgmt_message_builder_bench.sv ----
// Self-checking bench for the power-management message builder.
// Assumes an endpoint build with default parameters, a switch build and one link partner.
`timescale 1ns/1ps
`default_nettype none
module power_mgmt_message_builder_bench
  import pm_msg_pkg::*;
;
  logic        i_clk, i_srst, i_cfg_wr, i_tx_req, send;
  logic [1:0]  bad;
  logic [3:0]  rx_port;
  logic        sw_valid, sw_rx_fwd;
  logic [31:0] sw_dw0, sw_dw1;
  logic [7:0]  i_cfg_bus, exp_bus;
  logic [4:0]  i_cfg_dev, exp_dev;
  logic [2:0]  i_tx_func;
  pm_msg_t     i_tx_type, rx_type, o_rx_type;
  logic        o_tx_busy, o_tx_valid, p_valid, o_rx_valid;
  logic        o_rx_known, o_rx_fwd_up, o_rx_terminate;
  logic [31:0] o_tx_dw0, o_tx_dw1, o_tx_dw2, o_tx_dw3, p_dw0, p_dw1;
  int          n_mismatch, checks, cyc;

  pm_link_partner u_peer (.i_clk(i_clk), .i_send(send), .i_bad(bad),
    .i_type(rx_type), .o_valid(p_valid), .o_dw0(p_dw0), .o_dw1(p_dw1));

  pm_msg_builder u_dut (.i_clk(i_clk), .i_srst(i_srst),
    .i_cfg_wr(i_cfg_wr), .i_cfg_bus(i_cfg_bus), .i_cfg_dev(i_cfg_dev),
    .i_tx_req(i_tx_req), .i_tx_type(i_tx_type), .i_tx_func(i_tx_func),
    .o_tx_busy(o_tx_busy), .o_tx_valid(o_tx_valid), .o_tx_dw0(o_tx_dw0),
    .o_tx_dw1(o_tx_dw1), .o_tx_dw2(o_tx_dw2), .o_tx_dw3(o_tx_dw3),
    .i_rx_valid(p_valid), .i_rx_dw0(p_dw0), .i_rx_dw1(p_dw1),
    .i_rx_port(rx_port), .o_rx_valid(o_rx_valid), .o_rx_known(o_rx_known),
    .o_rx_type(o_rx_type), .o_rx_fwd_up(o_rx_fwd_up),
    .o_rx_terminate(o_rx_terminate));

  // Switch build: function zero in PME, PME forwarded, acks merged
  pm_msg_builder #(.IS_ENDPOINT(1'b0), .IS_SWITCH(1'b1)) u_dut_sw (
    .i_clk(i_clk), .i_srst(i_srst),
    .i_cfg_wr(i_cfg_wr), .i_cfg_bus(i_cfg_bus), .i_cfg_dev(i_cfg_dev),
    .i_tx_req(i_tx_req), .i_tx_type(i_tx_type), .i_tx_func(i_tx_func),
    .o_tx_busy(), .o_tx_valid(sw_valid), .o_tx_dw0(sw_dw0),
    .o_tx_dw1(sw_dw1), .o_tx_dw2(), .o_tx_dw3(),
    .i_rx_valid(p_valid), .i_rx_dw0(p_dw0), .i_rx_dw1(p_dw1),
    .i_rx_port(rx_port), .o_rx_valid(), .o_rx_known(), .o_rx_type(),
    .o_rx_fwd_up(sw_rx_fwd), .o_rx_terminate());

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cfg(input logic [7:0] b, input logic [4:0] d);
    @(posedge i_clk);
    i_cfg_wr <= 1'h1;
    i_cfg_bus <= b;
    i_cfg_dev <= d;
    exp_bus = b;
    exp_dev = d;
    @(posedge i_clk);
    i_cfg_wr <= 1'h0;
  endtask

  // Called just after a rising edge only
  task automatic tx_go(input pm_msg_t t, input logic [2:0] fn);
    i_tx_req <= 1'h1;
    i_tx_type <= t;
    i_tx_func <= fn;
  endtask

  // Request stays up one extra edge: the busy cycle must refuse it
  task automatic tx_chk(input logic [2:0] rt, input logic [7:0] cd,
                        input logic [2:0] efn);
    @(posedge i_clk);
    #1;
    check({30'h0, o_tx_busy, o_tx_valid}, 32'h3);
    check(o_tx_dw0, {3'h1, 2'h2, rt, 24'h000000});
    check(o_tx_dw1, {exp_bus, exp_dev, efn, 8'h00, cd});
    check(o_tx_dw2 | o_tx_dw3, 32'h0);
    @(posedge i_clk);
    i_tx_req <= 1'h0;
    #1;
    check({30'h0, o_tx_busy, o_tx_valid}, 32'h0);
  endtask

  task automatic tx(input pm_msg_t t, input logic [2:0] fn,
                    input logic [2:0] rt, input logic [7:0] cd,
                    input logic [2:0] efn);
    @(posedge i_clk);
    tx_go(t, fn);
    tx_chk(rt, cd, efn);
  endtask

  task automatic rx(input pm_msg_t t, input logic [1:0] b,
                    input logic [3:0] p, input logic [4:0] e,
                    input logic [4:0] m);
    int k;
    @(posedge i_clk);
    send <= 1'h1;
    rx_type <= t;
    bad <= b;
    rx_port <= p;
    @(posedge i_clk);
    send <= 1'h0;
    k = 0;
    do begin
      @(posedge i_clk);
      #1;
      k++;
    end while (o_rx_valid !== 1'h1 && k < 4);
    check({31'h0, o_rx_valid}, 32'h1);
    check({o_rx_known, o_rx_type, o_rx_fwd_up, o_rx_terminate} & m, e);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    repeat (5) @(posedge i_clk);
    #1;
    check({o_tx_valid, o_rx_valid, o_rx_type}, 4'h1);
    @(posedge i_clk);
    i_srst <= 1'h0;
    tx(MSG_TURN_OFF_ACK, 3'h2, 3'h5, 8'h1B, 3'h0);
  endtask

  task automatic t_tx_all();
    cfg(8'hA5, 5'h1B);
    tx(MSG_ASPM_REJECT, 3'h5, 3'h4, 8'h14, 3'h5);
    tx(MSG_PME, 3'h6, 3'h0, 8'h18, 3'h6);
    tx(MSG_TURN_OFF, 3'h7, 3'h3, 8'h19, 3'h7);
    tx(MSG_TURN_OFF_ACK, 3'h7, 3'h5, 8'h1B, 3'h0);
  endtask

  // Request taken on the edge right after the capture: new numbers used
  task automatic t_recapture();
    @(posedge i_clk);
    i_cfg_wr <= 1'h1;
    i_cfg_bus <= 8'h3C;
    i_cfg_dev <= 5'h02;
    exp_bus = 8'h3C;
    exp_dev = 5'h02;
    @(posedge i_clk);
    i_cfg_wr <= 1'h0;
    tx_go(MSG_PME, 3'h1);
    tx_chk(3'h0, 8'h18, 3'h1);
  endtask

  task automatic t_rx_all();
    rx(MSG_ASPM_REJECT, 2'h0, 4'h0, 5'h11, 5'h1F);
    rx(MSG_PME, 2'h0, 4'h0, 5'h14, 5'h1F);
    rx(MSG_TURN_OFF, 2'h0, 4'h0, 5'h18, 5'h1F);
    rx(MSG_TURN_OFF_ACK, 2'h0, 4'h0, 5'h1C, 5'h1F);
    rx(MSG_PME, 2'h1, 4'h0, 5'h00, 5'h10);
    rx(MSG_ASPM_REJECT, 2'h2, 4'h0, 5'h00, 5'h10);
  endtask

  // Ack goes up only once every downstream port has answered
  task automatic t_switch();
    int i;
    tx(MSG_PME, 3'h6, 3'h0, 8'h18, 3'h6);
    check(sw_dw1, {exp_bus, exp_dev, 3'h0, 8'h00, 8'h18});
    rx(MSG_PME, 2'h0, 4'h0, 5'h14, 5'h1F);
    check({31'h0, sw_rx_fwd}, 32'h1);
    for (i = 0; i < 4; i++) begin
      rx(MSG_TURN_OFF_ACK, 2'h0, 4'h1 << i, 5'h1C, 5'h1F);
      check({31'h0, sw_valid}, {31'h0, i == 3});
    end
    check(sw_dw0, {3'h1, 2'h2, 3'h5, 24'h000000});
    check(sw_dw1, {exp_bus, exp_dev, 3'h0, 8'h00, 8'h1B});
  endtask

  // Mid-run reset drops the captured numbers back to zero
  task automatic t_reset2();
    @(posedge i_clk);
    i_srst <= 1'h1;
    @(posedge i_clk);
    i_srst <= 1'h0;
    exp_bus = 8'h00;
    exp_dev = 5'h00;
    #1;
    check({o_tx_valid, o_rx_valid, o_rx_type}, 4'h1);
    tx(MSG_PME, 3'h3, 3'h0, 8'h18, 3'h3);
  endtask

  initial begin
    i_clk = 1'h0;
    forever #4 i_clk = ~i_clk;
  end

  // Whole run needs well under 300 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    {i_srst, i_cfg_wr, i_tx_req, send, bad} = 6'h20;
    rx_port = 4'h0;
    {i_cfg_bus, i_cfg_dev, i_tx_func, exp_bus, exp_dev} = 29'h0;
    i_tx_type = MSG_PME;
    rx_type = MSG_PME;
    t_reset();
    t_tx_all();
    t_recapture();
    t_rx_all();
    t_switch();
    t_reset2();
    finish_test();
  end
endmodule
`default_nettype wire
